// File: dcbo_cfg.svh
// Purpose: constants for the data cache block operation unit
// Assumes: big-endian bit numbering of the instruction word, bit 0 is the msb
// Notes:   timing-free; line size is in bytes, burst length in bus beats
`ifndef DCBO_CFG_SVH
`define DCBO_CFG_SVH

`define DCBO_PRIMARY_OP      6'h1F
`define DCBO_XO_INVALIDATE   10'h1D6
`define DCBO_XO_STORE        10'h036
`define DCBO_XO_TOUCH        10'h116
`define DCBO_XO_TOUCH_ST     10'h0F6
`define DCBO_LINE_BYTES      32
`define DCBO_OFF_BITS        5
`define DCBO_REG_ZERO        5'h00
`define DCBO_BEATS           8

`endif

// File: dcbo_pkg.sv
// Purpose: types shared by the data cache block operation unit
// Assumes: nothing beyond the constants header
// Notes:   operation codes are one-hot
package dcbo_pkg;
   typedef enum logic [4:0] {
      DCBO_OP_NONE = 5'h01,
      DCBO_OP_INV  = 5'h02,
      DCBO_OP_ST   = 5'h04,
      DCBO_OP_TCH  = 5'h08,
      DCBO_OP_TST  = 5'h10
   } dcbo_op_e;

   typedef enum logic [3:0] {
      DCBO_IDLE  = 4'h1,
      DCBO_WBACK = 4'h2,
      DCBO_FILL  = 4'h4,
      DCBO_DONE  = 4'h8
   } dcbo_state_e;
endpackage

// File: dcbo_unit.sv
// Purpose: decode and execute line invalidate, store-if-modified, touch and
//          touch-for-store against a direct-mapped tag store
// Assumes: translation, zone and attribute lookups are supplied by the core
// Notes:   line data itself lives outside; this unit owns tag, valid, modified
//
// Summary of operation
// - line invalidate: opcode 31, extended 470
// - store-if-modified: opcode 31, extended 54
// - touch: opcode 31, extended 278
// - touch-for-store: opcode 31, extended 246
// - base is zero when base field is 0
// - effective address is base plus index register
// - invalidate clears hit line regardless of cachability
// - invalidate drops modified data without write-back
// - invalidate in user mode raises program exception
// - invalidate zone faults with relocation on
// - invalidate faults on user attribute with enable
// - invalidate and store fault on translation miss
// - store writes modified hit line, clears modified
// - store is no-op on clean or miss
// - store faults only user no-access; invalidate as store
// - touch fills cachable missing line, else nothing
// - touch never faults; becomes no-operation instead
// - touch-for-store behaves exactly like touch
// - debug compare: invalidate/store stores, touches loads
// - reserved bits set: no program exception
// - each operation acts on one 32-byte line
`timescale 1ns/1ps
`include "dcbo_cfg.svh"

module dcbo_unit #(
   parameter int ADDR_W = 32,
   parameter int SETS_W = 6
) (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              instr_valid,
   input  wire logic [31:0]       instr_word,
   input  wire logic [ADDR_W-1:0] base_reg_value,
   input  wire logic [ADDR_W-1:0] index_reg_value,
   input  wire logic              user_mode,
   input  wire logic              reloc_enable,
   input  wire logic              tlb_hit,
   input  wire logic              zone_no_access,
   input  wire logic              zone_read_only,
   input  wire logic              cachable,
   input  wire logic              user_attr_zero,
   input  wire logic              user_attr_zero_exc_enable,
   input  wire logic              bus_beat_ack,
   output logic                   instr_ready,
   output logic                   instr_done,
   output logic                   exc_program,
   output logic                   exc_data_storage,
   output logic                   exc_tlb_miss,
   output logic                   dac_valid,
   output logic                   dac_is_store,
   output logic [ADDR_W-1:0]      dac_addr,
   output logic                   bus_req,
   output logic                   bus_write,
   output logic [ADDR_W-1:0]      bus_addr
);
   localparam int SETS  = 1 << SETS_W;
   localparam int TAG_W = ADDR_W - SETS_W - `DCBO_OFF_BITS;

   // =========================================================================
   // helpers
   // =========================================================================
   function automatic logic [SETS_W-1:0] set_of(input logic [ADDR_W-1:0] a);
      set_of = a[`DCBO_OFF_BITS +: SETS_W];
   endfunction

   function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
      tag_of = a[ADDR_W-1 -: TAG_W];
   endfunction

   // =========================================================================
   // decode
   // =========================================================================
   wire logic [5:0] f_primary  = instr_word[31:26];
   wire logic [4:0] f_base     = instr_word[20:16];
   wire logic [9:0] f_extended = instr_word[10:1];
   wire logic       is_x31     = instr_valid & (f_primary == `DCBO_PRIMARY_OP);
   // reserved bits 6-10 and 31 are not checked: no program exception for them
   wire logic d_inv = is_x31 & (f_extended == `DCBO_XO_INVALIDATE);
   wire logic d_st  = is_x31 & (f_extended == `DCBO_XO_STORE);
   wire logic d_tch = is_x31 & (f_extended == `DCBO_XO_TOUCH);
   wire logic d_tst = is_x31 & (f_extended == `DCBO_XO_TOUCH_ST);
   wire logic d_any = d_inv | d_st | d_tch | d_tst;

   wire logic [ADDR_W-1:0] base_val =
      (f_base == `DCBO_REG_ZERO) ? '0 : base_reg_value;
   wire logic [ADDR_W-1:0] effective_addr = base_val + index_reg_value;
   wire logic [ADDR_W-1:0] line_addr =
      {effective_addr[ADDR_W-1:`DCBO_OFF_BITS], {`DCBO_OFF_BITS{1'b0}}};

   // =========================================================================
   // exception checks
   // =========================================================================
   wire logic tlb_fault = reloc_enable & ~tlb_hit;
   wire logic inv_priv  = d_inv & user_mode;
   // invalidate is a store: both zone kinds and the user attribute apply
   wire logic inv_dsi = d_inv & ((reloc_enable & ((zone_no_access & user_mode)
                        | zone_read_only))
                        | (user_attr_zero & user_attr_zero_exc_enable));
   // store-if-modified is a load: only user no-access applies
   wire logic st_dsi  = d_st & reloc_enable & user_mode & zone_no_access;
   wire logic tlb_exc = (d_inv | d_st) & tlb_fault;
   wire logic any_exc = inv_priv | inv_dsi | st_dsi | tlb_exc;
   // touches raise no exception; translation and zone faults drop them quietly
   wire logic tch_ok  = (d_tch | d_tst) & ~tlb_fault & ~(reloc_enable
                        & ((zone_no_access & user_mode) | zone_read_only));

   // =========================================================================
   // tag store
   // =========================================================================
   logic [TAG_W-1:0] tag_mem [SETS];
   logic [SETS-1:0]  valid_r;
   logic [SETS-1:0]  dirty_r;

   wire logic [SETS_W-1:0] ea_set = set_of(effective_addr);
   wire logic hit = valid_r[ea_set] & (tag_mem[ea_set] == tag_of(effective_addr));

   // =========================================================================
   // sequencer
   // =========================================================================
   dcbo_pkg::dcbo_state_e state_r;
   dcbo_pkg::dcbo_state_e state_nxt;
   logic [2:0]            beat_r;
   logic [ADDR_W-1:0]     op_addr_r;
   wire logic [SETS_W-1:0] op_set = set_of(op_addr_r);
   wire logic last_beat = bus_beat_ack & (beat_r == 3'(`DCBO_BEATS - 1));

   wire logic take      = (state_r == dcbo_pkg::DCBO_IDLE) & d_any;
   wire logic do_inv    = take & d_inv & ~any_exc & hit;
   wire logic do_wback  = take & d_st & ~any_exc & hit & dirty_r[ea_set];
   wire logic do_fill   = take & tch_ok & cachable & ~hit;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dcbo_pkg::DCBO_IDLE: begin
            if (do_wback)
               state_nxt = dcbo_pkg::DCBO_WBACK;
            else if (do_fill)
               state_nxt = dcbo_pkg::DCBO_FILL;
         end
         dcbo_pkg::DCBO_WBACK,
         dcbo_pkg::DCBO_FILL: begin
            if (last_beat)
               state_nxt = dcbo_pkg::DCBO_DONE;
         end
         dcbo_pkg::DCBO_DONE:
            state_nxt = dcbo_pkg::DCBO_IDLE;
         default:
            state_nxt = dcbo_pkg::DCBO_IDLE;
      endcase
   end

   wire logic busy_nxt = (state_nxt != dcbo_pkg::DCBO_IDLE);
   wire logic quick_done = take & ~do_wback & ~do_fill;
   wire logic burst_end  = ((state_r == dcbo_pkg::DCBO_WBACK)
                           | (state_r == dcbo_pkg::DCBO_FILL)) & last_beat;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= dcbo_pkg::DCBO_IDLE;
         beat_r  <= 3'h0;
      end else begin
         state_r <= state_nxt;
         if (take)
            beat_r <= 3'h0;
         else if (bus_beat_ack)
            beat_r <= beat_r + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (take)
         op_addr_r <= line_addr;
   end

   // line state changes only after the whole burst
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         valid_r <= '0;
         dirty_r <= '0;
      end else if (do_inv) begin
         valid_r[ea_set] <= 1'b0;
         dirty_r[ea_set] <= 1'b0;
      end else if (burst_end & (state_r == dcbo_pkg::DCBO_WBACK)) begin
         dirty_r[op_set] <= 1'b0;
      end else if (burst_end) begin
         valid_r[op_set] <= 1'b1;
         dirty_r[op_set] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (burst_end & (state_r == dcbo_pkg::DCBO_FILL))
         tag_mem[op_set] <= tag_of(op_addr_r);
   end

   // =========================================================================
   // registered outputs
   // =========================================================================
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         instr_ready      <= 1'b0;
         instr_done       <= 1'b0;
         exc_program      <= 1'b0;
         exc_data_storage <= 1'b0;
         exc_tlb_miss     <= 1'b0;
         dac_valid        <= 1'b0;
         dac_is_store     <= 1'b0;
         dac_addr         <= '0;
      end else begin
         instr_ready      <= ~busy_nxt;
         instr_done       <= quick_done | burst_end;
         exc_program      <= take & inv_priv;
         exc_data_storage <= take & ~inv_priv & (inv_dsi | st_dsi);
         exc_tlb_miss     <= take & ~inv_priv & ~inv_dsi & ~st_dsi & tlb_exc;
         dac_valid        <= take;
         dac_is_store     <= take & (d_inv | d_st);
         if (take)
            dac_addr <= effective_addr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_req   <= 1'b0;
         bus_write <= 1'b0;
         bus_addr  <= '0;
      end else begin
         bus_req   <= (state_nxt == dcbo_pkg::DCBO_WBACK)
                      | (state_nxt == dcbo_pkg::DCBO_FILL);
         bus_write <= (state_nxt == dcbo_pkg::DCBO_WBACK);
         if (take)
            bus_addr <= line_addr;
      end
   end

   // =========================================================================
   // checks
   // =========================================================================
   a_user_inv_prog: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_inv & user_mode |=> exc_program & ~bus_req)
      else $error("user invalidate without program exception");
   a_touch_no_exc: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & (d_tch | d_tst) |=> ~exc_data_storage & ~exc_tlb_miss)
      else $error("touch raised a data exception");
   a_inv_no_wb: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_inv |=> ~bus_req ##1 ~bus_req)
      else $error("invalidate wrote back");
   a_inv_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
      do_inv |=> ~valid_r[$past(ea_set)])
      else $error("invalidate left line valid");
   a_st_tlb_miss: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_st & reloc_enable & ~tlb_hit & ~st_dsi |=> exc_tlb_miss)
      else $error("store missed tlb without exception");
   a_st_clean_nop: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_st & ~(hit & dirty_r[ea_set]) |=> ~bus_req & instr_done)
      else $error("store on clean line used bus");
   a_wb_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      do_wback |=> bus_req & bus_write & (bus_addr[`DCBO_OFF_BITS-1:0] == '0))
      else $error("write-back burst not started");
   a_fill_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
      do_fill |=> bus_req & ~bus_write)
      else $error("fill burst not started");
   a_dac_class: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take |=> dac_valid & (dac_is_store == $past(d_inv | d_st)))
      else $error("wrong address-compare class");
   a_state_late: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_r == dcbo_pkg::DCBO_FILL) & ~last_beat |=> $stable(valid_r))
      else $error("line state changed mid burst");
   a_dec_inval: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_inv |=> dac_valid & dac_is_store)
      else $error("invalidate not decoded");
   a_dec_store: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_st |=> dac_valid & dac_is_store)
      else $error("store-if-modified not decoded");
   a_dec_touch: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_tch |=> dac_valid & ~dac_is_store)
      else $error("touch not decoded");
   a_dec_touch_st: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_tst |=> dac_valid & ~dac_is_store)
      else $error("touch-for-store not decoded");
   a_base_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & (f_base == `DCBO_REG_ZERO) |=> dac_addr == $past(index_reg_value))
      else $error("zero base field not treated as zero");
   a_ea_sum: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & (f_base != `DCBO_REG_ZERO) |=> dac_addr == $past(base_reg_value + index_reg_value))
      else $error("effective address not base plus index");
   a_inv_miss_nop: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_inv & ~hit |=> $stable(valid_r) & ~bus_req)
      else $error("invalidate miss changed state");
   a_inv_ro_zone: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_inv & ~user_mode & reloc_enable & zone_read_only |=> exc_data_storage)
      else $error("privileged read-only zone not faulted");
   a_inv_attr: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_inv & ~user_mode & user_attr_zero & user_attr_zero_exc_enable |=> exc_data_storage)
      else $error("user attribute not faulted");
   a_st_ro_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_st & ~zone_no_access |=> ~exc_data_storage)
      else $error("store-if-modified faulted without no-access zone");
   a_wb_clean: assert property (@(posedge sys_clk) disable iff (sys_rst)
      burst_end & (state_r == dcbo_pkg::DCBO_WBACK) |=> ~dirty_r[$past(op_set)])
      else $error("write-back left line modified");
   a_st_miss_nop: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_st & ~hit |=> ~bus_req & $stable(dirty_r))
      else $error("store-if-modified miss did something");
   a_fill_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
      burst_end & (state_r == dcbo_pkg::DCBO_FILL) |=> valid_r[$past(op_set)])
      else $error("fill did not validate line");
   a_touch_uncach: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & (d_tch | d_tst) & ~cachable |=> ~bus_req & instr_done)
      else $error("uncachable touch used bus");
   a_touch_hit_nop: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & (d_tch | d_tst) & hit |=> ~bus_req)
      else $error("touch hit used bus");
   a_touch_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & (d_tch | d_tst) & reloc_enable & ~tlb_hit |=> ~bus_req & instr_done)
      else $error("faulting touch not dropped");
   a_tst_like_tch: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & d_tst & tch_ok & cachable & ~hit |=> bus_req & ~bus_write)
      else $error("touch-for-store differs from touch");
   a_priv_no_prog: assert property (@(posedge sys_clk) disable iff (sys_rst)
      take & ~user_mode |=> ~exc_program)
      else $error("program exception outside user mode");
   a_line_align: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_req |-> bus_addr[`DCBO_OFF_BITS-1:0] == '0)
      else $error("bus address not line aligned");
   a_burst_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
      burst_end |=> ~bus_req & instr_done)
      else $error("burst did not end after last beat");
   a_busy_ready: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_req |-> ~instr_ready)
      else $error("ready during burst");
   a_exc_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $onehot0({exc_program, exc_data_storage, exc_tlb_miss}))
      else $error("more than one exception at once");
endmodule

// File: dcbo_mem_model.sv
// Purpose: main memory seen through the processor bus, answering line bursts
// Assumes: one beat acknowledged per pulse of bus_beat_ack, eight beats a line
// Notes:   slow mode acknowledges only every other cycle; counts bursts by kind
`timescale 1ns/1ps

module dcbo_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        slow,
   input  wire logic        bus_req,
   input  wire logic        bus_write,
   input  wire logic [31:0] bus_addr,
   output logic             bus_beat_ack,
   output int               n_fill,
   output int               n_wback,
   output logic             last_write,
   output logic [31:0]      last_addr
);
   int   issued;
   logic req_q;
   logic phase;
   wire  give = bus_req && (issued < 8) && (!slow || phase);

   // =========================================================
   // beat acknowledge, never more than one line per burst
   always_ff @(posedge sys_clk) begin
      req_q <= bus_req & ~sys_rst;
      phase <= sys_rst ? 1'b0 : ~phase;
      if (sys_rst || !bus_req) begin
         issued       <= 0;
         bus_beat_ack <= 1'b0;
      end else begin
         bus_beat_ack <= give;
         issued       <= give ? issued + 1 : issued;
      end
      if (sys_rst) begin
         n_fill  <= 0;
         n_wback <= 0;
      end else if (bus_req && !req_q) begin
         n_fill     <= n_fill + (bus_write ? 0 : 1);
         n_wback    <= n_wback + (bus_write ? 1 : 0);
         last_write <= bus_write;
         last_addr  <= bus_addr;
      end
   end
endmodule

// File: dcbo_unit_test.sv
// Purpose: self-checking bench for the data cache block operation unit
// Assumes: memory model acknowledges bursts; flags packed user..attr enable
// Notes:   no way to dirty a line at the ports, so write-back is never expected
`timescale 1ns/1ps
`include "dcbo_cfg.svh"

module dcbo_unit_test;
   logic        sys_clk, sys_rst, instr_valid, slow, bus_beat_ack;
   logic [31:0] instr_word, base_reg_value, index_reg_value, dac_addr, bus_addr, last_addr;
   logic [7:0]  fl;
   logic        instr_ready, instr_done, exc_program, exc_data_storage, exc_tlb_miss;
   logic        dac_valid, dac_is_store, bus_req, bus_write, last_write;
   logic [4:0]  got, rsv;
   logic [31:0] got_addr;
   int          n_fill, n_wback, d_fill, d_wb, n_mismatch, check_count;

   dcbo_unit dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .base_reg_value(base_reg_value),
      .index_reg_value(index_reg_value), .user_mode(fl[7]), .reloc_enable(fl[6]),
      .tlb_hit(fl[5]), .zone_no_access(fl[4]), .zone_read_only(fl[3]), .cachable(fl[2]),
      .user_attr_zero(fl[1]), .user_attr_zero_exc_enable(fl[0]),
      .bus_beat_ack(bus_beat_ack), .instr_ready(instr_ready), .instr_done(instr_done),
      .exc_program(exc_program), .exc_data_storage(exc_data_storage),
      .exc_tlb_miss(exc_tlb_miss), .dac_valid(dac_valid), .dac_is_store(dac_is_store),
      .dac_addr(dac_addr), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr));

   dcbo_mem_model mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow), .bus_req(bus_req),
      .bus_write(bus_write), .bus_addr(bus_addr), .bus_beat_ack(bus_beat_ack),
      .n_fill(n_fill), .n_wback(n_wback), .last_write(last_write), .last_addr(last_addr));

   // =========================================================
   // helpers
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic op(input logic [9:0] xo, input logic [4:0] ra, input logic [31:0] b,
                     input logic [31:0] x, input logic [7:0] f);
      int n;
      int f0;
      int w0;
      f0 = n_fill;
      w0 = n_wback;
      @(posedge sys_clk);
      instr_word      <= {`DCBO_PRIMARY_OP, rsv, ra, 5'h03, xo, 1'b0};
      base_reg_value  <= b;
      index_reg_value <= x;
      fl              <= f;
      instr_valid     <= 1'b1;
      @(negedge sys_clk);
      n = 0;
      while (instr_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      chk(n < 50, "never ready");
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      @(negedge sys_clk);
      got      = {exc_program, exc_data_storage, exc_tlb_miss, dac_valid, dac_is_store};
      got_addr = dac_addr;
      n = 0;
      while (instr_done !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      chk(n < 100, "no completion");
      d_fill = n_fill - f0;
      d_wb   = n_wback - w0;
   endtask

   task automatic res_ok(input logic st, input logic [31:0] ea, input int df, input string m);
      chk(got === {3'b000, 1'b1, st} && got_addr === ea && d_fill == df && d_wb == 0, m);
   endtask

   task automatic res_exc(input logic [2:0] e, input string m);
      chk(got[4:2] === e && d_fill == 0 && d_wb == 0, m);
   endtask

   // =========================================================
   // scenarios
   task automatic t_touch;
      slow = 1'b1;
      op(`DCBO_XO_TOUCH, 5'h00, 32'hFFFF_FFFF, 32'h0000_1044, 8'h24);
      res_ok(1'b0, 32'h0000_1044, 1, "touch miss fill");
      chk(last_addr === 32'h0000_1040 && last_write === 1'b0, "fill line");
      op(`DCBO_XO_TOUCH, 5'h00, 32'h0, 32'h0000_105C, 8'h24);
      res_ok(1'b0, 32'h0000_105C, 0, "touch hit");
      slow = 1'b0;
      op(`DCBO_XO_TOUCH_ST, 5'h00, 32'h0, 32'h0000_2088, 8'h24);
      res_ok(1'b0, 32'h0000_2088, 1, "touch store fill");
      chk(last_addr === 32'h0000_2080 && last_write === 1'b0, "fill line");
      op(`DCBO_XO_TOUCH_ST, 5'h00, 32'h0, 32'h0000_3000, 8'h20);
      res_ok(1'b0, 32'h0000_3000, 0, "uncachable touch");
      $display("test touch done");
   endtask

   task automatic t_inval;
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0000_1000, 32'h0000_0050, 8'h20);
      res_ok(1'b1, 32'h0000_1050, 0, "invalidate hit");
      op(`DCBO_XO_TOUCH, 5'h00, 32'h0, 32'h0000_1040, 8'h24);
      res_ok(1'b0, 32'h0000_1040, 1, "line gone");
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0, 32'h0000_1040, 8'hA4);
      res_exc(3'b100, "user invalidate");
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0, 32'h0000_1040, 8'h6C);
      res_exc(3'b010, "read-only zone");
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0, 32'h0000_1040, 8'h74);
      res_exc(3'b000, "no-access privileged");
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0, 32'h0000_1040, 8'h27);
      res_exc(3'b010, "attribute fault");
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0, 32'h0000_1040, 8'h26);
      res_exc(3'b000, "attribute disabled");
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0, 32'h0000_1040, 8'h44);
      res_exc(3'b001, "translation miss");
      rsv = 5'h1F;
      op(`DCBO_XO_INVALIDATE, 5'h04, 32'h0, 32'h0000_1040, 8'h24);
      res_exc(3'b000, "reserved bits");
      rsv = 5'h00;
      $display("test invalidate done");
   endtask

   task automatic t_store;
      op(`DCBO_XO_STORE, 5'h00, 32'h0, 32'h0000_5000, 8'h24);
      res_ok(1'b1, 32'h0000_5000, 0, "store miss");
      op(`DCBO_XO_STORE, 5'h00, 32'h0, 32'h0000_2090, 8'h20);
      res_ok(1'b1, 32'h0000_2090, 0, "store clean hit");
      op(`DCBO_XO_STORE, 5'h00, 32'h0, 32'h0000_2090, 8'hF4);
      res_exc(3'b010, "user no-access");
      op(`DCBO_XO_STORE, 5'h00, 32'h0, 32'h0000_2090, 8'hEC);
      res_exc(3'b000, "read-only as load");
      op(`DCBO_XO_STORE, 5'h00, 32'h0, 32'h0000_2090, 8'h74);
      res_exc(3'b000, "privileged no-access");
      op(`DCBO_XO_STORE, 5'h00, 32'h0, 32'h0000_2090, 8'h44);
      res_exc(3'b001, "store translation miss");
      $display("test store done");
   endtask

   task automatic t_nofault;
      op(`DCBO_XO_TOUCH, 5'h00, 32'h0, 32'h0000_6000, 8'hC4);
      res_exc(3'b000, "touch miss quiet");
      op(`DCBO_XO_TOUCH_ST, 5'h00, 32'h0, 32'h0000_7000, 8'hF4);
      res_exc(3'b000, "touch zone quiet");
      $display("test touch faults done");
   endtask

   // =========================================================
   // run control
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      #200000;
      n_mismatch++;
      end_of_test;
   end

   initial begin
      sys_rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = 32'h0;
      base_reg_value = 32'h0;
      index_reg_value = 32'h0;
      fl = 8'h24;
      slow = 1'b0;
      rsv = 5'h00;
      n_mismatch = 0;
      check_count = 0;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_touch;
      t_inval;
      t_store;
      t_nofault;
      end_of_test;
   end
endmodule
